// >>> rtl/bec_pkg.sv
package bec_pkg;

	// Bus and datapath widths
	localparam int BEC_PADDR_W = 12;
	localparam int BEC_PDATA_W = 32;
	localparam int BEC_PIX_W = 16;
	localparam int BEC_MEM_AW = 20;
	localparam int BEC_DIM_W = 11;
	localparam int BEC_IDX_W = 9;

	// Source FIFO shape and level thresholds
	localparam int BEC_FIFO_DEPTH = 16;
	localparam int BEC_FIFO_PTR_W = 4;
	localparam int BEC_FIFO_CNT_W = 5;
	localparam logic [BEC_FIFO_CNT_W-1:0] BEC_FIFO_HALF = 5'h08;
	localparam logic [BEC_FIFO_CNT_W-1:0] BEC_FIFO_FULL = 5'h10;

	// Register indices; byte address is four times the index
	localparam logic [BEC_IDX_W-1:0] BEC_IDX_CTRL0 = 9'h100;
	localparam logic [BEC_IDX_W-1:0] BEC_IDX_CTRL1 = 9'h101;
	localparam logic [BEC_IDX_W-1:0] BEC_IDX_ROP = 9'h102;
	localparam logic [BEC_IDX_W-1:0] BEC_IDX_OP = 9'h103;
	localparam logic [BEC_IDX_W-1:0] BEC_IDX_SRC = 9'h104;
	localparam logic [BEC_IDX_W-1:0] BEC_IDX_DST = 9'h108;
	localparam logic [BEC_IDX_W-1:0] BEC_IDX_WIDTH = 9'h10c;
	localparam logic [BEC_IDX_W-1:0] BEC_IDX_HEIGHT = 9'h10d;
	localparam logic [BEC_IDX_W-1:0] BEC_IDX_PITCH = 9'h10e;
	localparam logic [BEC_IDX_W-1:0] BEC_IDX_FIFO = 9'h110;
	localparam logic [BEC_IDX_W-1:0] BEC_IDX_IRQ_STAT = 9'h114;
	localparam logic [BEC_IDX_W-1:0] BEC_IDX_IRQ_MASK = 9'h115;

	// Control register 0 and 1 fields
	localparam int BEC_BIT_GO_BUSY = 7;
	localparam int BEC_BIT_HAS_ENTRIES = 6;
	localparam int BEC_BIT_HALF_LEVEL = 5;
	localparam int BEC_BIT_AT_CAPACITY = 4;
	localparam int BEC_BIT_DEST_LINEAR = 1;
	localparam int BEC_BIT_SRC_LINEAR = 0;
	localparam int BEC_BIT_PIX_FORMAT = 0;

	// Interrupt status and mask layout
	localparam int BEC_IRQ_W = 2;
	localparam int BEC_IRQ_DONE = 0;
	localparam int BEC_IRQ_OVERFLOW = 1;

	// Operation codes
	localparam logic [3:0] BEC_OP_WRITE = 4'h0;
	localparam logic [3:0] BEC_OP_MOVE = 4'h1;
	localparam logic [3:0] BEC_OP_PATTERN = 4'h2;

	// Pattern tile is 8 by 8 pixels
	localparam int BEC_PAT_LOG = 3;

	// Byte lanes per colour format
	localparam logic [1:0] BEC_BE_8BPP = 2'h1;
	localparam logic [1:0] BEC_BE_16BPP = 2'h3;

	// Reset values
	localparam logic [3:0] BEC_ROP_RESET = 4'h0;
	localparam logic [3:0] BEC_OP_RESET = 4'h0;
	localparam logic [BEC_DIM_W-1:0] BEC_DIM_RESET = 11'h001;

	typedef enum logic [1:0] {
		BEC_ST_IDLE,
		BEC_ST_FETCH_SRC,
		BEC_ST_READ_DST,
		BEC_ST_WRITE_DST
	} bec_state_type;

endpackage : bec_pkg

// >>> rtl/bec_rop_unit.sv
`timescale 1ns/1ps
module bec_rop_unit
	import bec_pkg::*;
(
	input wire logic [3:0] rop_code, // Raster op selector
	input wire logic [BEC_PIX_W-1:0] src_pix, // Source or pattern pixel
	input wire logic [BEC_PIX_W-1:0] dst_pix, // Current destination pixel
	output logic [BEC_PIX_W-1:0] result_pix // Combined pixel
);

	// Code bit {s,d} is the truth table of the function: all 16 ops
	always_comb begin
		for (int i = 0; i < BEC_PIX_W; i++) begin
			result_pix[i] = rop_code[{src_pix[i], dst_pix[i]}];
		end
	end

endmodule : bec_rop_unit

// >>> rtl/bec_engine.sv
`timescale 1ns/1ps
//
// Contract
// - Writing 1 to bit 7 of control register 0 starts the operation chosen in the op register.
// - Bit 7 reads 0 when the engine is idle and ready, 1 while it is busy.
// - The FIFO-has-entries flag reads 1 when the FIFO holds one or more entries, else 0.
// - The FIFO-half-level flag reads 1 at 8 or more entries and 0 at 7 or fewer.
// - The FIFO-at-capacity flag reads 1 at 16 entries and 0 below that.
// - All 16 raster operations of source and destination are supported.
// - Results always go to the display buffer; source is buffer, buffer pattern or host.
// - Each result pixel comes from source, optional pattern and current destination; the engine takes the pattern in place of the source, not as a third operand.
// - Pixels of 8, 15 and 16 bits per pixel are handled.
// - The engine's registers occupy indices 100h through 115h.
// - Destination linear bit: 0 means rectangular region, 1 means contiguous block.
// - Source linear bit: 0 means rectangular region, 1 means contiguous block.
// - Colour format bit: 0 means 8-bit pixels, 1 means 16-bit pixels.
// - A 4-bit raster op code picks the function for write, move and pattern blits.
module bec_engine
	import bec_pkg::*;
(
	input wire logic pclk, // Bus clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [BEC_PADDR_W-1:0] paddr, // APB byte address
	input wire logic [BEC_PDATA_W-1:0] pwdata, // APB write data
	output logic [BEC_PDATA_W-1:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped
	output logic irq, // Level interrupt
	output logic mem_req, // Display buffer request
	output logic mem_we, // Display buffer write
	output logic [BEC_MEM_AW-1:0] mem_addr, // Pixel address
	output logic [1:0] mem_be, // Byte lanes
	output logic [BEC_PIX_W-1:0] mem_wdata, // Pixel write data
	input wire logic [BEC_PIX_W-1:0] mem_rdata, // Pixel read data
	input wire logic mem_ack // Request accepted
);

	////////////////////////////////////////////////////////////////////////////////

	function automatic logic reg_hit(input logic [BEC_PADDR_W-1:0] a,
			input logic [BEC_IDX_W-1:0] idx);
		reg_hit = (a == {1'b0, idx, 2'b00});
	endfunction : reg_hit

	function automatic logic [BEC_MEM_AW-1:0] step_ptr(input logic [BEC_MEM_AW-1:0] ptr,
			input logic [BEC_MEM_AW-1:0] row, input logic linear,
			input logic [BEC_DIM_W-1:0] pitch, input logic eol);
		if (!eol || linear) begin
			step_ptr = ptr + BEC_MEM_AW'(1);
		end else begin
			step_ptr = row + BEC_MEM_AW'(pitch);
		end
	endfunction : step_ptr

	function automatic logic [BEC_MEM_AW-1:0] pat_addr(input logic [BEC_MEM_AW-1:0] base,
			input logic [BEC_DIM_W-1:0] x, input logic [BEC_DIM_W-1:0] y);
		pat_addr = base + BEC_MEM_AW'({y[BEC_PAT_LOG-1:0], x[BEC_PAT_LOG-1:0]});
	endfunction : pat_addr

	////////////////////////////////////////////////////////////////////////////////

	logic wr_en;
	logic setup;
	logic mapped;
	logic go_busy_reg;
	logic dest_linear_layout_reg;
	logic src_linear_layout_reg;
	logic pixel_format_sel_reg;
	logic [3:0] raster_op_code_reg;
	logic [3:0] blit_op_select_reg;
	logic [BEC_MEM_AW-1:0] src_base_reg;
	logic [BEC_MEM_AW-1:0] dst_base_reg;
	logic [BEC_DIM_W-1:0] width_reg;
	logic [BEC_DIM_W-1:0] height_reg;
	logic [BEC_DIM_W-1:0] pitch_reg;
	logic [BEC_IRQ_W-1:0] irq_stat_reg;
	logic [BEC_IRQ_W-1:0] irq_mask_reg;
	logic [BEC_IRQ_W-1:0] irq_event;
	logic [BEC_PDATA_W-1:0] prdata_reg;
	logic [BEC_PDATA_W-1:0] rd_next;
	logic start;

	assign wr_en = psel & penable & pwrite;
	assign setup = psel & ~penable;
	assign mapped = reg_hit(paddr, BEC_IDX_CTRL0) | reg_hit(paddr, BEC_IDX_CTRL1)
		| reg_hit(paddr, BEC_IDX_ROP) | reg_hit(paddr, BEC_IDX_OP)
		| reg_hit(paddr, BEC_IDX_SRC) | reg_hit(paddr, BEC_IDX_DST)
		| reg_hit(paddr, BEC_IDX_WIDTH) | reg_hit(paddr, BEC_IDX_HEIGHT)
		| reg_hit(paddr, BEC_IDX_PITCH) | reg_hit(paddr, BEC_IDX_FIFO)
		| reg_hit(paddr, BEC_IDX_IRQ_STAT) | reg_hit(paddr, BEC_IDX_IRQ_MASK);
	// Zero wait states; unmapped access answers with an error
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = prdata_reg;
	// Launch only when idle; a go written while busy is dropped
	assign start = wr_en & reg_hit(paddr, BEC_IDX_CTRL0) & pwdata[BEC_BIT_GO_BUSY]
		& ~go_busy_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Source FIFO fed by host writes

	logic [BEC_PIX_W-1:0] fifo_mem [BEC_FIFO_DEPTH];
	logic [BEC_FIFO_PTR_W-1:0] fifo_wr_reg;
	logic [BEC_FIFO_PTR_W-1:0] fifo_rd_reg;
	logic [BEC_FIFO_CNT_W-1:0] fifo_cnt_reg;
	logic fifo_wr_try;
	logic fifo_push;
	logic fifo_pop;
	logic blit_fifo_has_entries;
	logic blit_fifo_half_level;
	logic blit_fifo_at_capacity;

	assign blit_fifo_has_entries = (fifo_cnt_reg != '0);
	assign blit_fifo_half_level = (fifo_cnt_reg >= BEC_FIFO_HALF);
	assign blit_fifo_at_capacity = (fifo_cnt_reg == BEC_FIFO_FULL);
	assign fifo_wr_try = wr_en & reg_hit(paddr, BEC_IDX_FIFO);
	assign fifo_push = fifo_wr_try & ~blit_fifo_at_capacity;

	always_ff @(posedge pclk) begin
		if (fifo_push) begin
			fifo_mem[fifo_wr_reg] <= pwdata[BEC_PIX_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fifo_wr_reg <= '0;
			fifo_rd_reg <= '0;
			fifo_cnt_reg <= '0;
		end else begin
			if (fifo_push) begin
				fifo_wr_reg <= fifo_wr_reg + BEC_FIFO_PTR_W'(1);
			end
			if (fifo_pop) begin
				fifo_rd_reg <= fifo_rd_reg + BEC_FIFO_PTR_W'(1);
			end
			if (fifo_push && !fifo_pop) begin
				fifo_cnt_reg <= fifo_cnt_reg + BEC_FIFO_CNT_W'(1);
			end else if (fifo_pop && !fifo_push) begin
				fifo_cnt_reg <= fifo_cnt_reg - BEC_FIFO_CNT_W'(1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Configuration registers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dest_linear_layout_reg <= 1'b0;
			src_linear_layout_reg <= 1'b0;
			pixel_format_sel_reg <= 1'b0;
			raster_op_code_reg <= BEC_ROP_RESET;
			blit_op_select_reg <= BEC_OP_RESET;
			src_base_reg <= '0;
			dst_base_reg <= '0;
			width_reg <= BEC_DIM_RESET;
			height_reg <= BEC_DIM_RESET;
			pitch_reg <= '0;
			irq_mask_reg <= '0;
		end else if (wr_en && !go_busy_reg) begin
			// Setup is frozen while a blit runs
			if (reg_hit(paddr, BEC_IDX_CTRL0)) begin
				dest_linear_layout_reg <= pwdata[BEC_BIT_DEST_LINEAR];
				src_linear_layout_reg <= pwdata[BEC_BIT_SRC_LINEAR];
			end else if (reg_hit(paddr, BEC_IDX_CTRL1)) begin
				pixel_format_sel_reg <= pwdata[BEC_BIT_PIX_FORMAT];
			end else if (reg_hit(paddr, BEC_IDX_ROP)) begin
				raster_op_code_reg <= pwdata[3:0];
			end else if (reg_hit(paddr, BEC_IDX_OP)) begin
				blit_op_select_reg <= pwdata[3:0];
			end else if (reg_hit(paddr, BEC_IDX_SRC)) begin
				src_base_reg <= pwdata[BEC_MEM_AW-1:0];
			end else if (reg_hit(paddr, BEC_IDX_DST)) begin
				dst_base_reg <= pwdata[BEC_MEM_AW-1:0];
			end else if (reg_hit(paddr, BEC_IDX_WIDTH)) begin
				width_reg <= pwdata[BEC_DIM_W-1:0];
			end else if (reg_hit(paddr, BEC_IDX_HEIGHT)) begin
				height_reg <= pwdata[BEC_DIM_W-1:0];
			end else if (reg_hit(paddr, BEC_IDX_PITCH)) begin
				pitch_reg <= pwdata[BEC_DIM_W-1:0];
			end else if (reg_hit(paddr, BEC_IDX_IRQ_MASK)) begin
				irq_mask_reg <= pwdata[BEC_IRQ_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupts: sticky, write one to clear, a new event beats the clear

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_reg <= '0;
		end else begin
			irq_stat_reg <= (irq_stat_reg
				& ~((wr_en && reg_hit(paddr, BEC_IDX_IRQ_STAT)) ? pwdata[BEC_IRQ_W-1:0] : '0))
				| irq_event;
		end
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

	////////////////////////////////////////////////////////////////////////////////
	// Read data captured in the setup phase

	always_comb begin
		rd_next = '0;
		if (reg_hit(paddr, BEC_IDX_CTRL0)) begin
			rd_next[BEC_BIT_GO_BUSY] = go_busy_reg;
			rd_next[BEC_BIT_HAS_ENTRIES] = blit_fifo_has_entries;
			rd_next[BEC_BIT_HALF_LEVEL] = blit_fifo_half_level;
			rd_next[BEC_BIT_AT_CAPACITY] = blit_fifo_at_capacity;
			rd_next[BEC_BIT_DEST_LINEAR] = dest_linear_layout_reg;
			rd_next[BEC_BIT_SRC_LINEAR] = src_linear_layout_reg;
		end else if (reg_hit(paddr, BEC_IDX_CTRL1)) begin
			rd_next[BEC_BIT_PIX_FORMAT] = pixel_format_sel_reg;
		end else if (reg_hit(paddr, BEC_IDX_ROP)) begin
			rd_next[3:0] = raster_op_code_reg;
		end else if (reg_hit(paddr, BEC_IDX_OP)) begin
			rd_next[3:0] = blit_op_select_reg;
		end else if (reg_hit(paddr, BEC_IDX_SRC)) begin
			rd_next[BEC_MEM_AW-1:0] = src_base_reg;
		end else if (reg_hit(paddr, BEC_IDX_DST)) begin
			rd_next[BEC_MEM_AW-1:0] = dst_base_reg;
		end else if (reg_hit(paddr, BEC_IDX_WIDTH)) begin
			rd_next[BEC_DIM_W-1:0] = width_reg;
		end else if (reg_hit(paddr, BEC_IDX_HEIGHT)) begin
			rd_next[BEC_DIM_W-1:0] = height_reg;
		end else if (reg_hit(paddr, BEC_IDX_PITCH)) begin
			rd_next[BEC_DIM_W-1:0] = pitch_reg;
		end else if (reg_hit(paddr, BEC_IDX_IRQ_STAT)) begin
			rd_next[BEC_IRQ_W-1:0] = irq_stat_reg;
		end else if (reg_hit(paddr, BEC_IDX_IRQ_MASK)) begin
			rd_next[BEC_IRQ_W-1:0] = irq_mask_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= '0;
		end else if (setup) begin
			prdata_reg <= rd_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pixel engine

	bec_state_type state_reg;
	logic [BEC_DIM_W-1:0] x_reg;
	logic [BEC_DIM_W-1:0] y_reg;
	logic [BEC_MEM_AW-1:0] src_ptr_reg;
	logic [BEC_MEM_AW-1:0] src_row_reg;
	logic [BEC_MEM_AW-1:0] dst_ptr_reg;
	logic [BEC_MEM_AW-1:0] dst_row_reg;
	logic [BEC_PIX_W-1:0] src_pix_reg;
	logic [BEC_PIX_W-1:0] rop_result;
	logic [BEC_MEM_AW-1:0] mem_addr_reg;
	logic [BEC_PIX_W-1:0] mem_wdata_reg;
	logic host_src;
	logic eol;
	logic last;
	logic [BEC_DIM_W-1:0] x_next;
	logic [BEC_DIM_W-1:0] y_next;
	logic [BEC_MEM_AW-1:0] src_ptr_next;
	logic [BEC_MEM_AW-1:0] dst_ptr_next;

	bec_rop_unit u_rop (
		.rop_code(raster_op_code_reg),
		.src_pix(src_pix_reg),
		.dst_pix(mem_rdata),
		.result_pix(rop_result)
	);

	assign host_src = (blit_op_select_reg == BEC_OP_WRITE);
	assign eol = (x_reg >= width_reg - BEC_DIM_W'(1));
	assign last = eol && (y_reg >= height_reg - BEC_DIM_W'(1));
	assign x_next = eol ? '0 : x_reg + BEC_DIM_W'(1);
	assign y_next = eol ? y_reg + BEC_DIM_W'(1) : y_reg;
	assign src_ptr_next = step_ptr(src_ptr_reg, src_row_reg, src_linear_layout_reg,
		pitch_reg, eol);
	assign dst_ptr_next = step_ptr(dst_ptr_reg, dst_row_reg, dest_linear_layout_reg,
		pitch_reg, eol);
	assign fifo_pop = (state_reg == BEC_ST_FETCH_SRC) && host_src && blit_fifo_has_entries;
	assign mem_req = (state_reg == BEC_ST_READ_DST) || (state_reg == BEC_ST_WRITE_DST)
		|| ((state_reg == BEC_ST_FETCH_SRC) && !host_src);
	assign mem_we = (state_reg == BEC_ST_WRITE_DST);
	assign mem_addr = mem_addr_reg;
	assign mem_wdata = mem_wdata_reg;
	// 15 bpp shares the 16-bit word format
	assign mem_be = pixel_format_sel_reg ? BEC_BE_16BPP : BEC_BE_8BPP;
	assign irq_event[BEC_IRQ_DONE] = mem_we && mem_ack && last;
	assign irq_event[BEC_IRQ_OVERFLOW] = fifo_wr_try && blit_fifo_at_capacity;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= BEC_ST_IDLE;
			go_busy_reg <= 1'b0;
		end else begin
			case (state_reg)
				BEC_ST_IDLE: begin
					if (start) begin
						state_reg <= BEC_ST_FETCH_SRC;
						go_busy_reg <= 1'b1;
					end
				end
				BEC_ST_FETCH_SRC: begin
					if (fifo_pop || (mem_req && mem_ack)) begin
						state_reg <= BEC_ST_READ_DST;
					end
				end
				BEC_ST_READ_DST: begin
					if (mem_ack) begin
						state_reg <= BEC_ST_WRITE_DST;
					end
				end
				BEC_ST_WRITE_DST: begin
					if (mem_ack) begin
						state_reg <= last ? BEC_ST_IDLE : BEC_ST_FETCH_SRC;
						go_busy_reg <= !last;
					end
				end
				default: begin
					state_reg <= BEC_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			x_reg <= '0;
			y_reg <= '0;
			src_ptr_reg <= '0;
			src_row_reg <= '0;
			dst_ptr_reg <= '0;
			dst_row_reg <= '0;
			src_pix_reg <= '0;
			mem_addr_reg <= '0;
			mem_wdata_reg <= '0;
		end else if (start) begin
			x_reg <= '0;
			y_reg <= '0;
			src_ptr_reg <= src_base_reg;
			src_row_reg <= src_base_reg;
			dst_ptr_reg <= dst_base_reg;
			dst_row_reg <= dst_base_reg;
			mem_addr_reg <= src_base_reg;
		end else if (fifo_pop) begin
			src_pix_reg <= fifo_mem[fifo_rd_reg];
			mem_addr_reg <= dst_ptr_reg;
		end else if (state_reg == BEC_ST_FETCH_SRC && mem_ack) begin
			src_pix_reg <= mem_rdata;
			mem_addr_reg <= dst_ptr_reg;
		end else if (state_reg == BEC_ST_READ_DST && mem_ack) begin
			mem_wdata_reg <= pixel_format_sel_reg ? rop_result
				: {8'h00, rop_result[7:0]};
		end else if (state_reg == BEC_ST_WRITE_DST && mem_ack && !last) begin
			x_reg <= x_next;
			y_reg <= y_next;
			src_ptr_reg <= src_ptr_next;
			dst_ptr_reg <= dst_ptr_next;
			if (eol) begin
				src_row_reg <= src_ptr_next;
				dst_row_reg <= dst_ptr_next;
			end
			// Pattern fill walks an 8x8 tile at the source base
			mem_addr_reg <= (blit_op_select_reg == BEC_OP_PATTERN)
				? pat_addr(src_base_reg, x_next, y_next) : src_ptr_next;
		end
	end

endmodule : bec_engine

// >>> test/bec_engine_properties.sv
`timescale 1ns/1ps
module bec_engine_properties
	import bec_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [BEC_PADDR_W-1:0] paddr, // APB address
	input wire logic [BEC_PDATA_W-1:0] pwdata, // APB write data
	input wire logic [BEC_PDATA_W-1:0] prdata, // APB read data
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic irq, // Interrupt
	input wire logic mem_req, // Buffer request
	input wire logic mem_we, // Buffer write
	input wire logic [BEC_MEM_AW-1:0] mem_addr, // Pixel address
	input wire logic [1:0] mem_be, // Byte lanes
	input wire logic [BEC_PIX_W-1:0] mem_wdata, // Write pixel
	input wire logic [BEC_PIX_W-1:0] mem_rdata, // Read pixel
	input wire logic mem_ack // Accept
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc;
	assign acc = psel && penable;
	////////////////////////////////////////////////////////////////
	a_unmapped_error: assert property (acc && (paddr < 12'h400 || paddr > 12'h467) |->
		pslverr && prdata == 32'h0000_0000) else $error("unmapped access not refused");
	a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
		&& $stable(mem_we) && $stable(mem_wdata)) else $error("request dropped or changed");
	a_write_has_req: assert property (mem_we |-> mem_req) else $error("write without request");
	a_write_ends: assert property (mem_req && mem_we && mem_ack |=> !mem_we)
		else $error("second write after result");
	a_read_follow: assert property (mem_req && !mem_we && mem_ack |=> mem_req)
		else $error("no request after operand read");
	a_lanes_legal: assert property (mem_req |-> mem_be == 2'h1 || mem_be == 2'h3)
		else $error("illegal byte lanes");
	a_narrow_upper: assert property (mem_we && mem_be == 2'h1 |-> mem_wdata[15:8] == 8'h00)
		else $error("upper byte set in narrow pixel");
	a_quiet_release: assert property ($rose(presetn) |-> !irq && !mem_req)
		else $error("busy or interrupt after reset");
	a_ready_zero_wait: assert property (acc |-> pready) else $error("ready low in access");
	////////////////////////////////////////////////////////////////
	c_write_done: cover property (mem_req && mem_we && mem_ack);
	c_stall: cover property (mem_req && !mem_ack ##1 mem_req);
	c_error: cover property (pslverr);
	c_irq: cover property (irq);
endmodule : bec_engine_properties

bind bec_engine bec_engine_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq), .mem_req(mem_req), .mem_we(mem_we),
	.mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
	.mem_ack(mem_ack));

// >>> test/bec_mem_model.sv
`timescale 1ns/1ps
module bec_mem_model
	import bec_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic mem_req, // Request
	input wire logic mem_we, // Write
	input wire logic [BEC_MEM_AW-1:0] mem_addr, // Pixel address
	input wire logic [1:0] mem_be, // Byte lanes
	input wire logic [BEC_PIX_W-1:0] mem_wdata, // Write pixel
	output logic [BEC_PIX_W-1:0] mem_rdata, // Read pixel
	output logic mem_ack, // Accept
	input wire logic [3:0] delay // Stall cycles before accept
);
	logic [BEC_PIX_W-1:0] mem [0:255];
	logic [3:0] wait_reg;
	// Plain always so the bench may preload the array
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ack <= 1'b0;
			wait_reg <= 4'h0;
			mem_rdata <= 16'h5a5a;
		end else if (mem_req && !mem_ack && wait_reg >= delay) begin
			mem_ack <= 1'b1;
			wait_reg <= 4'h0;
			mem_rdata <= mem[mem_addr[7:0]];
		end else begin
			// Data is only valid with ack; garble it otherwise
			mem_ack <= 1'b0;
			wait_reg <= mem_req ? wait_reg + 4'h1 : 4'h0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && mem_ack && mem_we) begin
				if (mem_be[0]) mem[mem_addr[7:0]][7:0] <= mem_wdata[7:0];
				if (mem_be[1]) mem[mem_addr[7:0]][15:8] <= mem_wdata[15:8];
			end
		end
	end
endmodule : bec_mem_model

// >>> test/blit_engine_control_status_bench.sv
`timescale 1ns/1ps
module blit_engine_control_status_bench;
	import bec_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic mem_req, mem_we, mem_ack;
	logic [BEC_PADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [BEC_MEM_AW-1:0] mem_addr;
	logic [1:0] mem_be;
	logic [15:0] mem_wdata, mem_rdata, s, d;
	logic [3:0] delay;
	logic err;
	int errors, cmp_count;

	bec_engine u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_be(mem_be), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
	bec_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack), .delay(delay));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("errors=%0d comparisons=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [8:0] idx, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= BEC_PADDR_W'({idx, 2'b00});
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// No wait limit here: the watchdog ends a hung transfer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wait_idle(input logic [7:0] exp = 8'h00);
		int n;
		n = 0;
		do begin
			apb(1'b0, BEC_IDX_CTRL0, 32'h0);
			n++;
		end while (rd[BEC_BIT_GO_BUSY] !== 1'b0 && n < 100);
		chk(rd[7:0], exp);
	endtask : wait_idle

	function automatic logic [15:0] rop_exp(input logic [3:0] r, input logic [15:0] a,
		input logic [15:0] b);
		return ({16{r[0]}} & ~a & ~b) | ({16{r[1]}} & ~a & b) | ({16{r[2]}} & a & ~b)
			| ({16{r[3]}} & a & b);
	endfunction : rop_exp
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		finish_test();
	end

	initial begin
		{psel, penable, pwrite} = 3'b000;
		paddr = '0;
		pwdata = '0;
		delay = 4'h3;
		errors = 0;
		cmp_count = 0;
		presetn = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, BEC_IDX_CTRL0, 0); chk(rd, 32'h0000_0000);
		apb(1'b0, BEC_IDX_WIDTH, 0); chk(rd, 32'h0000_0001);
		apb(1'b0, 9'h11a, 0); chk({err, rd[30:0]}, 32'h8000_0000);
		// Every raster op, single pixel, alternating move and pattern fill
		apb(1'b1, BEC_IDX_CTRL1, 32'h1);
		apb(1'b1, BEC_IDX_SRC, 32'h10);
		apb(1'b1, BEC_IDX_DST, 32'h20);
		for (int r = 0; r < 16; r++) begin
			s = 16'hc3a5 ^ 16'(r * 16'h0111);
			d = 16'h0ff0 ^ 16'(r * 16'h1010);
			u_mem.mem[8'h10] = s;
			u_mem.mem[8'h20] = d;
			apb(1'b1, BEC_IDX_ROP, 32'(r));
			apb(1'b1, BEC_IDX_OP, r[0] ? BEC_OP_MOVE : BEC_OP_PATTERN);
			apb(1'b1, BEC_IDX_CTRL0, 32'h80);
			apb(1'b0, BEC_IDX_CTRL0, 0); chk(rd[7], 1'b1);
			apb(1'b1, BEC_IDX_ROP, 32'h5);
			wait_idle();
			apb(1'b0, BEC_IDX_ROP, 0); chk(rd, 32'(r));
			chk(u_mem.mem[8'h20], rop_exp(4'(r), s, d));
		end
		// Done interrupt: mask, unmask, clear
		apb(1'b0, BEC_IDX_IRQ_STAT, 0); chk(rd[1:0], 2'b01);
		chk(irq, 1'b0);
		// Interrupt follows the write edge; look once it has settled
		apb(1'b1, BEC_IDX_IRQ_MASK, 32'h3);
		@(negedge pclk);
		chk(irq, 1'b1);
		apb(1'b1, BEC_IDX_IRQ_STAT, 32'h1);
		@(negedge pclk);
		chk(irq, 1'b0);
		// 2x2 move: rectangular source rows one pitch apart, linear destination
		for (int k = 0; k < 4; k++) begin
			u_mem.mem[8'h10 + (k / 2) * 8 + k % 2] = 16'h3c00 + k;
			u_mem.mem[8'h20 + k] = 16'hffff;
		end
		apb(1'b1, BEC_IDX_ROP, 32'hc);
		apb(1'b1, BEC_IDX_OP, BEC_OP_MOVE);
		apb(1'b1, BEC_IDX_WIDTH, 32'h2);
		apb(1'b1, BEC_IDX_HEIGHT, 32'h2);
		apb(1'b1, BEC_IDX_PITCH, 32'h8);
		apb(1'b1, BEC_IDX_CTRL0, 32'h82);
		wait_idle(8'h02);
		for (int k = 0; k < 4; k++) chk(u_mem.mem[8'h20 + k], 16'h3c00 + k);
		apb(1'b1, BEC_IDX_WIDTH, 32'h1);
		apb(1'b1, BEC_IDX_HEIGHT, 32'h1);
		// Narrow pixels write only the low byte; the buffer's upper byte keeps its old value
		apb(1'b1, BEC_IDX_CTRL1, 32'h0);
		u_mem.mem[8'h10] = 16'h1234;
		u_mem.mem[8'h20] = 16'hffff;
		apb(1'b1, BEC_IDX_ROP, 32'hc);
		apb(1'b1, BEC_IDX_OP, BEC_OP_MOVE);
		apb(1'b1, BEC_IDX_CTRL0, 32'h80);
		wait_idle();
		chk(u_mem.mem[8'h20], 16'hff34);
		apb(1'b1, BEC_IDX_IRQ_STAT, 32'h3);
		// Host source: fill FIFO to capacity, watch level flags, overflow
		apb(1'b1, BEC_IDX_CTRL1, 32'h1);
		apb(1'b1, BEC_IDX_OP, BEC_OP_WRITE);
		apb(1'b1, BEC_IDX_DST, 32'h40);
		apb(1'b1, BEC_IDX_WIDTH, 32'h10);
		for (int k = 1; k <= 17; k++) begin
			apb(1'b1, BEC_IDX_FIFO, 32'(16'h0a00 + k));
			apb(1'b0, BEC_IDX_CTRL0, 0);
			chk(rd[7:4], {1'b0, 1'b1, k >= 8, k >= 16});
		end
		chk(irq, 1'b1);
		apb(1'b0, BEC_IDX_IRQ_STAT, 0); chk(rd[1:0], 2'b10);
		apb(1'b1, BEC_IDX_IRQ_STAT, 32'h2);
		delay <= 4'h0;
		// Destination is read before it is written; unknown data would spoil the result
		for (int k = 0; k < 16; k++) u_mem.mem[8'h40 + k] = 16'h0000;
		apb(1'b1, BEC_IDX_CTRL0, 32'h80);
		wait_idle();
		for (int k = 0; k < 16; k++) chk(u_mem.mem[8'h40 + k], 16'h0a01 + k);
		finish_test();
	end
endmodule : blit_engine_control_status_bench
